// [stc_consts.svh]
// Constants for the sixteen-bit timer counter core
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
// Register offsets
`define STC_ADDR_CTRL 4'h0
`define STC_ADDR_COUNT 4'h1
`define STC_ADDR_PERIOD 4'h2
`define STC_ADDR_STATUS 4'h3
// Control field positions
`define STC_CTRL_MODE_LO 0
`define STC_CTRL_MODE_HI 1
`define STC_CTRL_CLEAR 2
`define STC_CTRL_SRC_LO 3
`define STC_CTRL_SRC_HI 4
`define STC_CTRL_ID_LO 5
`define STC_CTRL_ID_HI 6
`define STC_CTRL_IDEX_LO 7
`define STC_CTRL_IDEX_HI 9
// Status field positions
`define STC_STAT_OVF 0
`define STC_STAT_PM 1
`define STC_STAT_DOWN 2
// Values
`define STC_ZERO16 16'h0000
`define STC_ONE16 16'h0001
`define STC_MAX16 16'hFFFF
`define STC_ZERO3 3'h0
`define STC_ONE3 3'h1
`endif

// [stc_pkg.sv]
// Types shared by the timer counter core
package stc_pkg;
    // Counting modes
    typedef enum logic [1:0]
    {
        STC_STOP = 2'h0,
        STC_UP = 2'h1,
        STC_CONT = 2'h2,
        STC_UPDOWN = 2'h3
    } stc_mode_type;
    // Clock source choices
    typedef enum logic [1:0]
    {
        STC_SRC_EXT = 2'h0,
        STC_SRC_AUX = 2'h1,
        STC_SRC_SUB = 2'h2,
        STC_SRC_EXT2 = 2'h3
    } stc_src_type;
endpackage

// [stc_divider.sv]
// Two-stage tick divider for the timer clock
`timescale 1ns/1ps
`include "stc_consts.svh"
module stc_divider
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic src_tick_i,
    input wire logic [1:0] id_sel_i,
    input wire logic [2:0] idex_sel_i,
    output logic tick_o
);
    import stc_pkg::*;
    logic [2:0] first_count; // First stage counter
    logic [2:0] second_count; // Second stage counter
    logic first_tick; // First stage output
    logic [2:0] first_limit; // First stage terminal value

    // Terminal value of divide by 1, 2, 4 or 8
    always_comb
    begin
        first_limit = 3'((4'h1 << id_sel_i) - 4'h1);
        first_tick = src_tick_i && (first_count == first_limit);
    end

    // First stage: restart on clear, so first edge after clear counts
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_i)
            first_count <= `STC_ZERO3;
        else if (src_tick_i)
        begin
            if (first_count == first_limit)
                first_count <= `STC_ZERO3;
            else
                first_count <= first_count + `STC_ONE3;
        end
    end

    // Second stage: divide by idex + 1, registered output
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_i)
        begin
            second_count <= `STC_ZERO3;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= 1'b0;
            if (first_tick)
            begin
                if (second_count == idex_sel_i)
                begin
                    second_count <= `STC_ZERO3;
                    tick_o <= 1'b1;
                end
                else
                    second_count <= second_count + `STC_ONE3;
            end
        end
    end
endmodule

// [stc_timer.sv]
// Sixteen-bit timer counter core with four counting modes
// Notes on behaviour
// - 16-bit counter steps each timer tick
// - Clear zeroes count, dividers and direction
// - Software count write applies immediately
// - Source select picks aux, subsystem, external
// - First divider: 1, 2, 4 or 8
// - Second divider: one through eight
// - After clear, first source edge clocks
// - Counts only when mode nonzero, source runs
// - Up, up/down: zero period stops; nonzero restarts upward
// - Mode: stop, up, continuous, up/down
// - Up mode wraps after period value
// - Up: count above period restarts from zero
// - Up: match at period, overflow at wrap
// - Up: period shrink below count rolls over
// - Continuous wraps at FFFF, sets overflow
// - Up/down counts zero-period-zero repeatedly
// - Direction latched across stop
// - Up/down flags at period and 1-to-0
// - Down descent ignores period change
// - Up/down: smaller period turns counter down
// - Period register writes are unbuffered
// - Flags only when counting, not loading
`timescale 1ns/1ps
`include "stc_consts.svh"
module stc_timer
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic aux_tick_i,
    input wire logic subsystem_tick_i,
    input wire logic external_timer_clock_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic [15:0] count_value_o,
    output logic period_match_o,
    output logic overflow_o
);
    import stc_pkg::*;

    logic [9:0] ctrl; // Control register
    logic [15:0] count_value; // The counter
    logic [15:0] period_register; // Period / compare zero
    logic count_down; // Latched direction
    logic overflow_flag; // Sticky overflow
    logic period_match_flag; // Sticky period match
    logic ext_prev; // Previous external pin level
    logic src_tick; // Selected source event
    logic tick; // Divided timer tick
    logic [15:0] next_count; // Counter next value
    logic next_down; // Direction next value
    logic set_ovf; // Overflow event this tick
    logic set_pm; // Period match event this tick
    logic count_step; // A tick that really moves the count
    logic zero_period_wr; // Zero written to period in up modes
    logic clear_bit; // Clear control
    stc_mode_type mode; // Decoded mode
    stc_src_type src; // Decoded source
    logic wr_ctrl; // Control write strobe
    logic wr_count; // Count write strobe
    logic wr_period; // Period write strobe
    logic wr_status; // Status write strobe
    logic [15:0] status_word; // Status read value

    // Address match helper
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    // Write decode
    always_comb
    begin
        wr_ctrl = wr_i && hit(addr_i, `STC_ADDR_CTRL);
        wr_count = wr_i && hit(addr_i, `STC_ADDR_COUNT);
        wr_period = wr_i && hit(addr_i, `STC_ADDR_PERIOD);
        wr_status = wr_i && hit(addr_i, `STC_ADDR_STATUS);
    end

    // Field decode
    // mode field decode
    always_comb
    begin
        mode = stc_mode_type'(ctrl[`STC_CTRL_MODE_HI:`STC_CTRL_MODE_LO]);
        src = stc_src_type'(ctrl[`STC_CTRL_SRC_HI:`STC_CTRL_SRC_LO]);
        clear_bit = ctrl[`STC_CTRL_CLEAR];
    end

    // Control register
    // reset to stop mode
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ctrl <= 10'h000;
        else if (wr_ctrl)
            ctrl <= wdata_i[9:0];
    end

    // Period register, written straight through
    // unbuffered period write
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            period_register <= `STC_ZERO16;
        else if (wr_period)
            period_register <= wdata_i;
    end

    // External pin edge history
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ext_prev <= 1'b0;
        else
            ext_prev <= external_timer_clock_i;
    end

    // Source selection as one-cycle event
    // source select
    always_comb
    begin
        case (src)
            STC_SRC_AUX: src_tick = aux_tick_i;
            STC_SRC_SUB: src_tick = subsystem_tick_i;
            STC_SRC_EXT: src_tick = external_timer_clock_i && !ext_prev;
            STC_SRC_EXT2: src_tick = external_timer_clock_i && !ext_prev;
            default: src_tick = 1'b0;
        endcase
    end

    // Cascaded dividers
    // divider chain
    stc_divider u_div
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(clear_bit),
        .src_tick_i(src_tick),
        .id_sel_i(ctrl[`STC_CTRL_ID_HI:`STC_CTRL_ID_LO]),
        .idex_sel_i(ctrl[`STC_CTRL_IDEX_HI:`STC_CTRL_IDEX_LO]),
        .tick_o(tick)
    );

    // Next count, direction and events for one tick
    // counting
    always_comb
    begin
        next_count = count_value;
        next_down = count_down;
        set_ovf = 1'b0;
        set_pm = 1'b0;
        case (mode)
            STC_UP:
            begin
                next_down = 1'b0;
                if (count_value >= period_register)
                begin
                    next_count = `STC_ZERO16;
                    set_ovf = (count_value == period_register);
                end
                else
                begin
                    next_count = count_value + `STC_ONE16;
                    set_pm = (next_count == period_register);
                end
            end
            STC_CONT:
            begin
                next_count = count_value + `STC_ONE16;
                set_ovf = (count_value == `STC_MAX16);
                set_pm = (next_count == period_register);
            end
            STC_UPDOWN:
            begin
                if (count_down)
                begin
                    if (count_value == `STC_ZERO16)
                    begin
                        next_down = 1'b0;
                        next_count = `STC_ONE16;
                        set_pm = (period_register == `STC_ONE16);
                    end
                    else
                    begin
                        next_count = count_value - `STC_ONE16;
                        set_ovf = (count_value == `STC_ONE16);
                    end
                end
                else if (count_value >= period_register)
                begin
                    next_down = 1'b1;
                    next_count = count_value - `STC_ONE16;
                    set_ovf = (count_value == `STC_ONE16);
                end
                else
                begin
                    next_count = count_value + `STC_ONE16;
                    next_down = (next_count == period_register);
                    set_pm = (next_count == period_register);
                end
            end
            default:
            begin
                next_count = count_value;
            end
        endcase
    end

    // Counted step: no count write, clear or zero period in the way
    // step qualification
    always_comb
    begin
        zero_period_wr = wr_period && wdata_i == `STC_ZERO16 &&
                         (mode == STC_UP || mode == STC_UPDOWN);
        count_step = tick && mode != STC_STOP && !clear_bit && !wr_count &&
                     !zero_period_wr && !(period_register == `STC_ZERO16 &&
                     (mode == STC_UP || mode == STC_UPDOWN));
    end

    // Counter and direction latch
    // counter update
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_bit)
        begin
            count_value <= `STC_ZERO16;
            count_down <= 1'b0;
        end
        else if (wr_count)
            count_value <= wdata_i;
        else if (zero_period_wr)
        begin
            // Zero period halts and readies an upward restart
            count_value <= `STC_ZERO16;
            count_down <= 1'b0;
        end
        else if (count_step)
        begin
            count_value <= next_count;
            count_down <= next_down;
        end
    end

    // Sticky flags; a set beats a software clear
    // flags only on counted ticks
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            overflow_flag <= 1'b0;
            period_match_flag <= 1'b0;
        end
        else
        begin
            if (count_step && set_ovf)
                overflow_flag <= 1'b1;
            else if (wr_status && wdata_i[`STC_STAT_OVF])
                overflow_flag <= 1'b0;
            if (count_step && set_pm)
                period_match_flag <= 1'b1;
            else if (wr_status && wdata_i[`STC_STAT_PM])
                period_match_flag <= 1'b0;
        end
    end

    // Status word
    always_comb
    begin
        status_word = `STC_ZERO16;
        status_word[`STC_STAT_OVF] = overflow_flag;
        status_word[`STC_STAT_PM] = period_match_flag;
        status_word[`STC_STAT_DOWN] = count_down;
    end

    // Read data one cycle after strobe
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rdata_o <= `STC_ZERO16;
        else if (rd_i)
        begin
            case (addr_i)
                `STC_ADDR_CTRL: rdata_o <= {6'h00, ctrl};
                `STC_ADDR_COUNT: rdata_o <= count_value;
                `STC_ADDR_PERIOD: rdata_o <= period_register;
                `STC_ADDR_STATUS: rdata_o <= status_word;
                default: rdata_o <= `STC_ZERO16;
            endcase
        end
        else
            rdata_o <= `STC_ZERO16;
    end

    // Registered copies for the outputs
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            count_value_o <= `STC_ZERO16;
            period_match_o <= 1'b0;
            overflow_o <= 1'b0;
        end
        else
        begin
            count_value_o <= count_value;
            period_match_o <= period_match_flag;
            overflow_o <= overflow_flag;
        end
    end

    // Clear holds counter at zero
    AST_CLEAR_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
        clear_bit |=> (count_value == `STC_ZERO16 && !count_down))
        else $error("count not zero after clear");

    // Count write lands next cycle
    AST_COUNT_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_count && !clear_bit) |=> (count_value == $past(wdata_i)))
        else $error("count write not applied");

    // Stop mode holds the count
    AST_STOP_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
        (mode == STC_STOP && !wr_count && !clear_bit && !wr_period)
        |=> $stable(count_value))
        else $error("count moved while stopped");

    // Up mode never passes period by counting
    AST_UP_WRAP: assert property (@(posedge clk_i) disable iff (reset_i)
        (tick && mode == STC_UP && count_value == period_register &&
         period_register != `STC_ZERO16 && !wr_count && !clear_bit &&
         !wr_period) |=> (count_value == `STC_ZERO16 && overflow_flag))
        else $error("up mode failed to wrap");

    // Continuous wrap sets overflow
    AST_CONT_OVF: assert property (@(posedge clk_i) disable iff (reset_i)
        (tick && mode == STC_CONT && count_value == `STC_MAX16 &&
         !wr_count && !clear_bit) |=> (count_value == `STC_ZERO16 &&
         overflow_flag))
        else $error("continuous wrap missing overflow");

    // Up/down reaching period turns down and flags match
    AST_UD_PEAK: assert property (@(posedge clk_i) disable iff (reset_i)
        (count_step && mode == STC_UPDOWN && !count_down &&
         count_value + `STC_ONE16 == period_register && !wr_count &&
         !clear_bit && !wr_period) |=> (count_down && period_match_flag))
        else $error("up/down peak mishandled");

    // Descent continues while counting down
    AST_UD_DESCENT: assert property (@(posedge clk_i) disable iff (reset_i)
        (count_step && mode == STC_UPDOWN && count_down &&
         count_value != `STC_ZERO16 && !wr_count && !clear_bit &&
         !wr_period) |=> (count_value == $past(count_value) - `STC_ONE16))
        else $error("descent interrupted");

    // Direct load sets no flags
    AST_NO_LOAD_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_count && !overflow_flag && !period_match_flag)
        |=> (!overflow_flag && !period_match_flag))
        else $error("flag set by load");
endmodule

// [stc_timer_tb.sv]
// Self-checking testbench for the timer counter core
`timescale 1ns/1ps
`include "stc_consts.svh"
module testbench;
import stc_pkg::*;
logic clk_i;
logic reset_i;
logic aux_tick_i;
logic subsystem_tick_i;
logic external_timer_clock_i;
logic [3:0] addr_i;
logic [15:0] wdata_i;
logic wr_i;
logic rd_i;
logic [15:0] rdata_o;
logic [15:0] count_value_o;
logic period_match_o;
logic overflow_o;
int failures;
int total_checks;
int cyc;
int seed;
int i;
int p;
int r;
logic [15:0] v;
// Reference model state
logic [15:0] m_cnt;
logic [15:0] m_per;
logic [1:0] m_mode;
logic [1:0] m_src;
logic m_down;
logic m_ovf;
logic m_pm;
int m_div;
int m_ratio;

stc_timer u_stc_timer
(
    .clk_i(clk_i),
    .reset_i(reset_i),
    .aux_tick_i(aux_tick_i),
    .subsystem_tick_i(subsystem_tick_i),
    .external_timer_clock_i(external_timer_clock_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .count_value_o(count_value_o),
    .period_match_o(period_match_o),
    .overflow_o(overflow_o)
);

// Free-running 50 MHz clock
initial
begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
end

// Hang guard
always @(posedge clk_i)
begin
    cyc++;
    if (cyc == 60000)
    begin
        failures++;
        test_done();
    end
end

// Value comparison
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask

// One timer clock step of the model
function void model_tick();
    if (m_mode == 2'h2)
    begin
        m_cnt = m_cnt + 16'h0001;
        if (m_cnt == 16'h0000) m_ovf = 1'b1;
        // Period acts as a plain compare value here
        m_pm = m_pm | (m_cnt == m_per);
    end
    else if (m_mode != 2'h0 && m_per != 16'h0000)
    begin
        if (m_mode == 2'h3 && m_down && m_cnt == 16'h0000)
        begin
            // Bottom reached: turn upward, direction clears here
            m_down = 1'b0;
            m_cnt = 16'h0001;
            m_pm = m_pm | (m_per == 16'h0001);
        end
        else if (m_mode == 2'h3 && (m_down || m_cnt >= m_per))
        begin
            // Descent, or a period cut below the count turns it down
            m_down = 1'b1;
            m_cnt = m_cnt - 16'h0001;
            m_ovf = m_ovf | (m_cnt == 16'h0000);
        end
        else if (m_mode == 2'h1 && m_cnt >= m_per)
        begin
            m_ovf = m_ovf | (m_cnt == m_per);
            m_cnt = 16'h0000;
            m_down = 1'b0;
        end
        else
        begin
            m_cnt = m_cnt + 16'h0001;
            m_pm = m_pm | (m_cnt == m_per);
            m_down = (m_mode == 2'h3) && (m_cnt == m_per);
        end
    end
endfunction

// One source event through both divider stages
function void model_src();
    if (m_div + 1 >= m_ratio)
    begin
        m_div = 0;
        model_tick();
    end
    else m_div++;
endfunction

// Register write, mirrored in the model
task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    begin
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        case (a)
            `STC_ADDR_CTRL:
            begin
                m_mode = d[1:0];
                m_src = d[4:3];
                m_ratio = (1 << d[6:5]) * (int'(d[9:7]) + 1);
                if (d[2])
                begin
                    m_cnt = 16'h0000;
                    m_div = 0;
                    m_down = 1'b0;
                end
            end
            `STC_ADDR_COUNT: m_cnt = d;
            `STC_ADDR_PERIOD:
            begin
                m_per = d;
                if (d == 16'h0000 && m_mode[0])
                begin
                    m_cnt = 16'h0000;
                    m_down = 1'b0;
                end
            end
            `STC_ADDR_STATUS:
            begin
                m_ovf = m_ovf & ~d[0];
                m_pm = m_pm & ~d[1];
            end
            default: ;
        endcase
        // Let an edge pass so the strobe is not driven twice at once
        @(posedge clk_i);
    end
endtask

// Register read, data taken in the following cycle
task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    begin
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge clk_i);
    end
endtask

// Count, flags and direction against the model
task automatic check_all();
    begin
        rreg(`STC_ADDR_COUNT, v);
        chk(v, m_cnt);
        chk(count_value_o, m_cnt);
        rreg(`STC_ADDR_STATUS, v);
        chk(v, {13'h0000, m_down, m_pm, m_ovf});
        chk({14'h0000, period_match_o, overflow_o}, {14'h0000, m_pm, m_ovf});
    end
endtask

// One source event: 0 external pin, 1 aux, 2 subsystem
task automatic pulse(input int k);
    begin
        if (k == 1) aux_tick_i <= 1'b1;
        else if (k == 2) subsystem_tick_i <= 1'b1;
        else external_timer_clock_i <= 1'b1;
        @(posedge clk_i);
        aux_tick_i <= 1'b0;
        subsystem_tick_i <= 1'b0;
        @(posedge clk_i);
        external_timer_clock_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        if (k == m_src || (k == 0 && m_src == 2'h3)) model_src();
    end
endtask

// Several events, settle, then compare
task automatic ticks(input int k, input int n);
    begin
        repeat (n) pulse(k);
        repeat (4) @(posedge clk_i);
        check_all();
    end
endtask

// Final report
task test_done();
    begin
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
endtask

// Main sequence
initial
begin
    {aux_tick_i, subsystem_tick_i, external_timer_clock_i} = 3'h0;
    {addr_i, wdata_i, wr_i, rd_i} = 22'h000000;
    {m_cnt, m_per, m_mode, m_src, m_down, m_ovf, m_pm} = 39'h0;
    {failures, total_checks, cyc, m_div, m_ratio} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    reset_i = 1'b1;
    seed = $urandom(96102);
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    check_all();
    rreg(`STC_ADDR_CTRL, v);
    chk(v, 16'h0000);
    wreg(4'hF, 16'h1234);
    rreg(4'hF, v);
    chk(v, 16'h0000);
    // Stop mode holds the count
    wreg(`STC_ADDR_CTRL, 16'h0010);
    ticks(2, 3);
    // Each source code against each source
    wreg(`STC_ADDR_PERIOD, 16'h0064);
    for (i = 0; i < 4; i++)
    begin
        wreg(`STC_ADDR_CTRL, 16'(i << 3) | 16'h0001);
        for (p = 0; p < 3; p++) ticks(p, 2);
    end
    // Up mode over two periods
    p = 2 + $urandom % 8;
    wreg(`STC_ADDR_CTRL, 16'h0014);
    wreg(`STC_ADDR_STATUS, 16'h0003);
    wreg(`STC_ADDR_PERIOD, 16'(p));
    rreg(`STC_ADDR_PERIOD, v);
    chk(v, 16'(p));
    wreg(`STC_ADDR_CTRL, 16'h0011);
    for (i = 0; i < 2 * p + 3; i++) ticks(2, 1);
    wreg(`STC_ADDR_PERIOD, m_per + 16'h0003);
    for (i = 0; i < 6; i++) ticks(2, 1);
    // Direct load: immediate, no flags
    wreg(`STC_ADDR_STATUS, 16'h0003);
    wreg(`STC_ADDR_COUNT, m_per);
    check_all();
    ticks(2, 1);
    // Count above period on entering up mode
    wreg(`STC_ADDR_CTRL, 16'h0010);
    wreg(`STC_ADDR_STATUS, 16'h0003);
    wreg(`STC_ADDR_COUNT, m_per + 16'h0014);
    wreg(`STC_ADDR_CTRL, 16'h0011);
    ticks(2, 1);
    // Zero period halts, nonzero restarts from zero
    wreg(`STC_ADDR_PERIOD, 16'h0000);
    ticks(2, 3);
    wreg(`STC_ADDR_PERIOD, 16'h0004);
    ticks(2, 3);
    // Continuous wrap at the top
    // stop before reconfiguring
    wreg(`STC_ADDR_CTRL, 16'h0010);
    wreg(`STC_ADDR_PERIOD, 16'h0100);
    wreg(`STC_ADDR_COUNT, 16'hFFFE);
    wreg(`STC_ADDR_CTRL, 16'h0012);
    for (i = 0; i < 3; i++) ticks(2, 1);
    // Up/down with a period cut during descent
    p = 3 + $urandom % 6;
    wreg(`STC_ADDR_CTRL, 16'h0014);
    wreg(`STC_ADDR_STATUS, 16'h0003);
    wreg(`STC_ADDR_PERIOD, 16'(p));
    wreg(`STC_ADDR_CTRL, 16'h0013);
    for (i = 0; i < 3 * p + 2; i++)
    begin
        if (i == p + 1) wreg(`STC_ADDR_PERIOD, 16'(p - 1));
        ticks(2, 1);
    end
    // Direction kept across stop, reset by clear
    wreg(`STC_ADDR_CTRL, 16'h0010);
    ticks(2, 2);
    wreg(`STC_ADDR_CTRL, 16'h0013);
    ticks(2, 1);
    wreg(`STC_ADDR_CTRL, 16'h0014);
    check_all();
    wreg(`STC_ADDR_CTRL, 16'h0013);
    ticks(2, 1);
    // Every first-stage setting with a second-stage ratio
    wreg(`STC_ADDR_PERIOD, 16'h0100);
    for (i = 0; i < 4; i++)
    begin
        p = (i == 0) ? 7 : (i == 1) ? 0 : $urandom % 8;
        r = (1 << i) * (p + 1);
        wreg(`STC_ADDR_CTRL, 16'((i << 5) | (p << 7)) | 16'h0014);
        wreg(`STC_ADDR_CTRL, 16'((i << 5) | (p << 7)) | 16'h0012);
        ticks(2, 2 * r);
    end
    // Random runs in up and up/down modes
    for (i = 0; i < 8; i++)
    begin
        wreg(`STC_ADDR_CTRL, 16'h0014);
        wreg(`STC_ADDR_PERIOD, 16'(1 + $urandom % 12));
        wreg(`STC_ADDR_CTRL, ($urandom % 2) ? 16'h0011 : 16'h0013);
        ticks(2, $urandom % 30);
    end
    test_done();
end
endmodule
